// ### inc/fes_pkg.sv
package fes_pkg;

  // ****************************************
  // register bus
  // ****************************************
  localparam int FES_AW = 4;
  localparam int FES_DW = 32;
  localparam logic [3:0] FES_OFF_STATUS = 4'h0;
  localparam logic [3:0] FES_OFF_CTRL = 4'h4;
  localparam logic [3:0] FES_OFF_IRQ_STAT = 4'h8;
  localparam logic [3:0] FES_OFF_IRQ_MASK = 4'hC;

  // ****************************************
  // status word layout
  // ****************************************
  localparam int FES_IBUS_LSB = 27;
  localparam int FES_DBUS_LSB = 25;
  localparam int FES_B1CNT_LSB = 22;
  localparam int FES_B0CNT_LSB = 17;
  localparam int FES_SIGN_LSB = 14;
  localparam int FES_B1RD_LSB = 11;
  localparam int FES_B0RD_LSB = 9;
  localparam int FES_CODE_W = 2;
  localparam int FES_CNT_W = 3;
  localparam int FES_SIGN_W = 3;
  localparam logic [31:0] FES_STATUS_RST = 32'h0000_0000;

  // ****************************************
  // outcome codes
  // ****************************************
  typedef enum logic [1:0] {
    code_clean = 2'h0,
    code_uncorrected = 2'h1,
    code_fixed_single = 2'h2,
    code_single_and_double = 2'h3
  } fes_ecc_code_t;

  // ****************************************
  // sources
  // ****************************************
  localparam int FES_NSRC = 4;
  localparam int FES_SRC_IBUS = 0;
  localparam int FES_SRC_DBUS = 1;
  localparam int FES_SRC_BANK0 = 2;
  localparam int FES_SRC_BANK1 = 3;

  // ****************************************
  // control and interrupt bits
  // ****************************************
  localparam int FES_CTRL_W = 3;
  localparam int FES_CTRL_SYSEXC = 0;
  localparam int FES_CTRL_B0_IE = 1;
  localparam int FES_CTRL_B1_IE = 2;
  localparam logic [2:0] FES_CTRL_RST = 3'h0;
  localparam int FES_IRQ_W = 4;
  localparam int FES_IRQ_UNCORR = 0;
  localparam int FES_IRQ_CORR = 1;
  localparam int FES_IRQ_SIGN = 2;
  localparam int FES_IRQ_OVFL = 3;
  localparam logic [3:0] FES_IRQ_RST = 4'h0;

endpackage

// ### inc/fes_src_if.sv
interface fes_src_if;
  import fes_pkg::*;
  logic ev_valid;
  logic [FES_CODE_W-1:0] ev_code;
  logic cap_en;
  logic rd_clr;
  logic [FES_CODE_W-1:0] field;
  logic tally_run;
  modport ctl (output ev_valid, output ev_code, output cap_en, output rd_clr,
               input field, input tally_run);
  modport fld (input ev_valid, input ev_code, input cap_en, input rd_clr,
               output field, output tally_run);
endinterface

// ### verilog/fes_read_field.sv
module fes_read_field
  import fes_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  fes_src_if.fld src
);

  logic [FES_CODE_W-1:0] field;
  logic [FES_CODE_W-1:0] next_field;
  logic armed;

  // ****************************************
  // read-clear outcome field
  // ****************************************
  // codes are bit flags: bit1 single fixed, bit0 double left, so or-ing gives 11 for both
  always_comb begin
    next_field = field;
    if (src.rd_clr) begin
      next_field = '0;
    end
    if (src.ev_valid && src.cap_en) begin
      // new outcome survives a clear in the same cycle
      next_field = (src.rd_clr ? '0 : field) | src.ev_code;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      field <= '0;
    end else begin
      field <= next_field;
    end
  end

  // ****************************************
  // tally window
  // ****************************************
  // window opens once the field holds code_fixed_single alone (not 11) and closes on the status read
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      armed <= 1'b0;
    end else if (src.rd_clr) begin
      armed <= 1'b0;
    end else if (field == code_fixed_single) begin
      armed <= 1'b1;
    end
  end

  assign src.field = field;
  assign src.tally_run = armed | (field == code_fixed_single);

endmodule

// ### verilog/fes_tally.sv
module fes_tally
  import fes_pkg::*;
#(
  parameter int W = FES_CNT_W
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic run,
  input wire logic hit,
  input wire logic rd_clr,
  output logic [W-1:0] count,
  output logic ovfl
);

  localparam logic [W-1:0] MAX = '1;

  // saturates rather than wrapping so software never sees a small count after many errors
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count <= '0;
    end else if (rd_clr) begin
      count <= '0;
    end else if (run && hit && count != MAX) begin
      count <= count + W'(1);
    end
  end

  assign ovfl = run & hit & (count == MAX) & ~rd_clr;

endmodule

// ### verilog/fes_ecc_status.sv
module fes_ecc_status
  import fes_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [FES_AW-1:0] reg_addr,
  input wire logic [FES_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [FES_DW-1:0] reg_rdata,
  input wire logic ibus_ecc_valid,
  input wire logic [FES_CODE_W-1:0] ibus_ecc_code,
  input wire logic dbus_ecc_valid,
  input wire logic [FES_CODE_W-1:0] dbus_ecc_code,
  input wire logic bank0_ecc_valid,
  input wire logic [FES_CODE_W-1:0] bank0_ecc_code,
  input wire logic bank1_ecc_valid,
  input wire logic [FES_CODE_W-1:0] bank1_ecc_code,
  input wire logic sig_check_valid,
  input wire logic [FES_SIGN_W-1:0] sig_check_code,
  output logic irq
);

  // ****************************************
  // declarations
  // ****************************************
  logic sel_status;
  logic sel_ctrl;
  logic sel_irq_stat;
  logic sel_irq_mask;
  logic status_rd;
  logic [FES_CTRL_W-1:0] ctrl;
  logic [FES_IRQ_W-1:0] irq_stat;
  logic [FES_IRQ_W-1:0] irq_mask;
  logic [FES_IRQ_W-1:0] irq_set;
  logic [FES_IRQ_W-1:0] next_irq_stat;
  logic [FES_SIGN_W-1:0] signature_check_ecc_result;
  logic [FES_DW-1:0] flash_status_word;
  logic [FES_DW-1:0] next_rdata;
  logic [FES_NSRC-1:0] ev_valid_v;
  logic [FES_CODE_W-1:0] ev_code_v [FES_NSRC];
  logic [FES_NSRC-1:0] cap_en_v;
  logic [FES_CODE_W-1:0] field_v [FES_NSRC];
  logic [FES_NSRC-1:0] run_v;
  logic [FES_CODE_W-1:0] instr_fetch_ecc_result;
  logic [FES_CODE_W-1:0] data_read_ecc_result;
  logic [FES_CODE_W-1:0] bank0_read_ecc_result;
  logic [FES_CODE_W-1:0] bank1_read_ecc_result;
  logic [FES_CNT_W-1:0] bank0_corrected_tally;
  logic [FES_CNT_W-1:0] bank1_corrected_tally;
  logic bank0_ovfl;
  logic bank1_ovfl;
  logic any_uncorr;
  logic any_corr;

  // ****************************************
  // address decode
  // ****************************************
  assign sel_status = (reg_addr == FES_OFF_STATUS);
  assign sel_ctrl = (reg_addr == FES_OFF_CTRL);
  assign sel_irq_stat = (reg_addr == FES_OFF_IRQ_STAT);
  assign sel_irq_mask = (reg_addr == FES_OFF_IRQ_MASK);

  // reading the word is what clears the read-clear fields and both tallies
  assign status_rd = reg_rd & sel_status;

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl <= FES_CTRL_RST;
    end else if (reg_wr && sel_ctrl) begin
      ctrl <= reg_wdata[FES_CTRL_W-1:0];
    end
  end

  // ****************************************
  // event sources
  // ****************************************
  assign ev_valid_v[FES_SRC_IBUS] = ibus_ecc_valid;
  assign ev_valid_v[FES_SRC_DBUS] = dbus_ecc_valid;
  assign ev_valid_v[FES_SRC_BANK0] = bank0_ecc_valid;
  assign ev_valid_v[FES_SRC_BANK1] = bank1_ecc_valid;
  assign ev_code_v[FES_SRC_IBUS] = ibus_ecc_code;
  assign ev_code_v[FES_SRC_DBUS] = dbus_ecc_code;
  assign ev_code_v[FES_SRC_BANK0] = bank0_ecc_code;
  assign ev_code_v[FES_SRC_BANK1] = bank1_ecc_code;

  // bus fields follow the system exception enable, bank fields their own interrupt enable
  assign cap_en_v[FES_SRC_IBUS] = ctrl[FES_CTRL_SYSEXC];
  assign cap_en_v[FES_SRC_DBUS] = ctrl[FES_CTRL_SYSEXC];
  assign cap_en_v[FES_SRC_BANK0] = ctrl[FES_CTRL_B0_IE];
  assign cap_en_v[FES_SRC_BANK1] = ctrl[FES_CTRL_B1_IE];

  // ****************************************
  // read-clear outcome fields
  // ****************************************
  fes_src_if src [FES_NSRC] ();

  for (genvar g = 0; g < FES_NSRC; g++) begin : g_src
    assign src[g].ev_valid = ev_valid_v[g];
    assign src[g].ev_code = ev_code_v[g];
    assign src[g].cap_en = cap_en_v[g];
    assign src[g].rd_clr = status_rd;
    assign field_v[g] = src[g].field;
    assign run_v[g] = src[g].tally_run;

    fes_read_field u_field (
      .clk_sys (clk_sys),
      .srst (srst),
      .src (src[g])
    );
  end

  assign instr_fetch_ecc_result = field_v[FES_SRC_IBUS];
  assign data_read_ecc_result = field_v[FES_SRC_DBUS];
  assign bank0_read_ecc_result = field_v[FES_SRC_BANK0];
  assign bank1_read_ecc_result = field_v[FES_SRC_BANK1];

  // ****************************************
  // single-bit tallies per bank
  // ****************************************
  fes_tally #(
    .W (FES_CNT_W)
  ) u_bank0_tally (
    .clk_sys (clk_sys),
    .srst (srst),
    .run (run_v[FES_SRC_BANK0]),
    .hit (bank0_ecc_valid & bank0_ecc_code[1]),
    .rd_clr (status_rd),
    .count (bank0_corrected_tally),
    .ovfl (bank0_ovfl)
  );

  fes_tally #(
    .W (FES_CNT_W)
  ) u_bank1_tally (
    .clk_sys (clk_sys),
    .srst (srst),
    .run (run_v[FES_SRC_BANK1]),
    .hit (bank1_ecc_valid & bank1_ecc_code[1]),
    .rd_clr (status_rd),
    .count (bank1_corrected_tally),
    .ovfl (bank1_ovfl)
  );

  // ****************************************
  // signature check outcome
  // ****************************************
  // not read-clear: it describes the check made after reset and stays until the next one
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      signature_check_ecc_result <= '0;
    end else if (sig_check_valid) begin
      signature_check_ecc_result <= sig_check_code;
    end
  end

  // ****************************************
  // status word
  // ****************************************
  always_comb begin
    flash_status_word = FES_STATUS_RST;
    flash_status_word[FES_IBUS_LSB +: FES_CODE_W] = instr_fetch_ecc_result;
    flash_status_word[FES_DBUS_LSB +: FES_CODE_W] = data_read_ecc_result;
    flash_status_word[FES_B1CNT_LSB +: FES_CNT_W] = bank1_corrected_tally;
    flash_status_word[FES_B0CNT_LSB +: FES_CNT_W] = bank0_corrected_tally;
    flash_status_word[FES_SIGN_LSB +: FES_SIGN_W] = signature_check_ecc_result;
    flash_status_word[FES_B1RD_LSB +: FES_CODE_W] = bank1_read_ecc_result;
    flash_status_word[FES_B0RD_LSB +: FES_CODE_W] = bank0_read_ecc_result;
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  always_comb begin
    any_uncorr = 1'b0;
    any_corr = 1'b0;
    for (int i = 0; i < FES_NSRC; i++) begin
      any_uncorr = any_uncorr | (ev_valid_v[i] & cap_en_v[i] & ev_code_v[i][0]);
      any_corr = any_corr | (ev_valid_v[i] & cap_en_v[i] & ev_code_v[i][1]);
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[FES_IRQ_UNCORR] = any_uncorr;
    irq_set[FES_IRQ_CORR] = any_corr;
    irq_set[FES_IRQ_SIGN] = sig_check_valid & (sig_check_code != '0);
    irq_set[FES_IRQ_OVFL] = bank0_ovfl | bank1_ovfl;
  end

  // write one to clear; a new event in the same cycle keeps its bit
  always_comb begin
    next_irq_stat = irq_stat;
    if (reg_wr && sel_irq_stat) begin
      next_irq_stat = irq_stat & ~reg_wdata[FES_IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | irq_set;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_stat <= FES_IRQ_RST;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_mask <= FES_IRQ_RST;
    end else if (reg_wr && sel_irq_mask) begin
      irq_mask <= reg_wdata[FES_IRQ_W-1:0];
    end
  end

  // one cycle behind the status bits, the price of a flop-driven output
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // the word is sampled before the clear lands, so the read returns what was caught
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        FES_OFF_STATUS: next_rdata = flash_status_word;
        FES_OFF_CTRL: next_rdata[FES_CTRL_W-1:0] = ctrl;
        FES_OFF_IRQ_STAT: next_rdata[FES_IRQ_W-1:0] = irq_stat;
        FES_OFF_IRQ_MASK: next_rdata[FES_IRQ_W-1:0] = irq_mask;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ### tb/fes_ecc_status_sva.sv
module fes_ecc_status_sva
  import fes_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [FES_AW-1:0] reg_addr,
  input wire logic [FES_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [FES_DW-1:0] reg_rdata,
  input wire logic ibus_ecc_valid,
  input wire logic [FES_CODE_W-1:0] ibus_ecc_code,
  input wire logic dbus_ecc_valid,
  input wire logic [FES_CODE_W-1:0] dbus_ecc_code,
  input wire logic bank0_ecc_valid,
  input wire logic bank1_ecc_valid,
  input wire logic sig_check_valid,
  input wire logic [FES_SIGN_W-1:0] sig_check_code,
  input wire logic irq
);
  // ****
  // shadow of the enables, needed to know when capture is expected
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [2:0] ctrl_q;
  logic [3:0] mask_q;
  wire logic rd_st = reg_rd && reg_addr == FES_OFF_STATUS;
  wire logic quiet = !(ibus_ecc_valid || dbus_ecc_valid || bank0_ecc_valid || bank1_ecc_valid);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_q <= 3'h0;
    end else if (reg_wr && reg_addr == FES_OFF_CTRL) begin
      ctrl_q <= reg_wdata[2:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mask_q <= 4'h0;
    end else if (reg_wr && reg_addr == FES_OFF_IRQ_MASK) begin
      mask_q <= reg_wdata[3:0];
    end
  end
  sequence s_late_rd;
    !rd_st ##1 rd_st;
  endsequence
  sequence s_rd2;
    rd_st && quiet ##1 rd_st;
  endsequence
  // ****
  // checks
  // ****
  a_reset_quiet: assert property ($fell(srst) |-> !irq && reg_rdata == 32'h0) else $error("not quiet after reset");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata not idle");
  a_resv_zero: assert property (reg_rdata[31:29] == 3'h0 && reg_rdata[21:20] == 2'h0) else $error("reserved set");
  a_unmapped_zero: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0) else $error("unmapped");
  a_ibus_catch: assert property (ctrl_q[0] && ibus_ecc_valid ##1 s_late_rd |=>
    (reg_rdata[28:27] & $past(ibus_ecc_code, 3)) == $past(ibus_ecc_code, 3)) else $error("ibus code lost");
  a_dbus_catch: assert property (ctrl_q[0] && dbus_ecc_valid ##1 s_late_rd |=>
    (reg_rdata[26:25] & $past(dbus_ecc_code, 3)) == $past(dbus_ecc_code, 3)) else $error("dbus code lost");
  a_read_clear: assert property (s_rd2 |=> (reg_rdata & 32'h1FCE_1E00) == 32'h0) else $error("not cleared");
  a_sig_kept: assert property (rd_st && !sig_check_valid ##1 rd_st |=>
    reg_rdata[16:14] == $past(reg_rdata[16:14])) else $error("signature result cleared");
  a_sig_catch: assert property (sig_check_valid ##1 !sig_check_valid ##0 s_late_rd |=>
    reg_rdata[16:14] == $past(sig_check_code, 3)) else $error("signature result lost");
  a_irq_rise: assert property (ctrl_q[0] && ibus_ecc_valid && (ibus_ecc_code & mask_q[1:0]) != 2'h0
    && !(reg_wr && reg_addr == FES_OFF_IRQ_MASK) |-> ##2 irq) else $error("irq missing");
endmodule

// ### tb/test_fes_ecc_status.sv
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module test_fes_ecc_status
  import fes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  logic [4:0] ev_v = 5'h0;
  logic [1:0] ev_c [4] = '{default: 2'h0};
  logic [2:0] sig_c = 3'h0;
  logic rd_d = 1'b0;
  logic [31:0] expq [$];
  logic [31:0] exp_v;
  logic [1:0] dc, b1f, b0f;
  logic [2:0] sg;
  integer seed = 32'h56f0;
  int mismatches = 0;
  int compares = 0;
  fes_ecc_status u_fes_ecc_status (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .ibus_ecc_valid(ev_v[0]), .ibus_ecc_code(ev_c[0]), .dbus_ecc_valid(ev_v[1]), .dbus_ecc_code(ev_c[1]),
    .bank0_ecc_valid(ev_v[2]), .bank0_ecc_code(ev_c[2]), .bank1_ecc_valid(ev_v[3]), .bank1_ecc_code(ev_c[3]),
    .sig_check_valid(ev_v[4]), .sig_check_code(sig_c));
  initial forever #20 clk_sys = ~clk_sys;
  // ****
  // bus and event drivers
  // ****
  task acc(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    if (r) expq.push_back(e);
  endtask
  // also drops the bus strobes, so an event may follow an access directly
  task ev(input int s, input logic [2:0] c);
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    ev_v <= 5'h1 << s;
    if (s < 4) ev_c[s] <= c[1:0];
    else sig_c <= c;
    @(posedge clk_sys);
    ev_v <= 5'h0;
  endtask
  task chk_irq(input logic e);
    repeat (3) ev(0, 3'h0);
    @(negedge clk_sys);
    `CHK("irq", e, irq)
  endtask
  function logic [31:0] st(logic [1:0] ib, db, logic [2:0] c1, c0, s, logic [1:0] b1, b0);
    return {3'h0, ib, db, c1, 2'h0, c0, s, 1'b0, b1, b0, 9'h0};
  endfunction
  task close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****
  // read data watcher
  // ****
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_d) begin
      exp_v = (expq.size() > 0) ? expq.pop_front() : ~reg_rdata;
      `CHK("rdata", exp_v, reg_rdata)
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    acc(1'b1, 1'b0, FES_OFF_STATUS, 32'hFFFF_FFFF, 32'h0);
    acc(1'b1, 1'b0, 4'h2, 32'hFFFF_FFFF, 32'h0);
    for (int a = 0; a < 16; a++) acc(1'b0, 1'b1, 4'(a), 32'h0, 32'h0);
    ev(0, 3'h3);
    ev(1, 3'h3);
    acc(1'b0, 1'b1, FES_OFF_STATUS, 32'h0, 32'h0);
    $display("test reset done");
    acc(1'b1, 1'b0, FES_OFF_CTRL, 32'h7, 32'h0);
    acc(1'b0, 1'b1, FES_OFF_CTRL, 32'h0, 32'h7);
    for (int i = 0; i < 4; i++) begin
      dc = 2'($random(seed));
      ev(0, 3'(i));
      ev(1, {1'b0, dc});
      acc(1'b0, 1'b1, FES_OFF_STATUS, 32'h0, st(2'(i), dc, 3'h0, 3'h0, 3'h0, 2'h0, 2'h0));
      acc(1'b0, 1'b1, FES_OFF_STATUS, 32'h0, 32'h0);
    end
    ev(0, 3'h2);
    ev(0, 3'h1);
    acc(1'b0, 1'b1, FES_OFF_STATUS, 32'h0, st(2'h3, 2'h0, 3'h0, 3'h0, 3'h0, 2'h0, 2'h0));
    acc(1'b0, 1'b1, FES_OFF_IRQ_STAT, 32'h0, 32'h3);
    // a set mask bit lets its status bit through; the mask resets closed
    chk_irq(1'b0);
    acc(1'b1, 1'b0, FES_OFF_IRQ_MASK, 32'hF, 32'h0);
    chk_irq(1'b1);
    acc(1'b1, 1'b0, FES_OFF_IRQ_MASK, 32'h0, 32'h0);
    chk_irq(1'b0);
    acc(1'b1, 1'b0, FES_OFF_IRQ_STAT, 32'h3, 32'h0);
    acc(1'b1, 1'b0, FES_OFF_IRQ_MASK, 32'hF, 32'h0);
    chk_irq(1'b0);
    $display("test codes done");
    b1f = 2'h2;
    b0f = 2'h3;
    ev(3, 3'h2);
    ev(2, 3'h2);
    ev(2, 3'h1);
    for (int i = 0; i < 5; i++) begin
      dc = {1'b1, 1'($random(seed))};
      b1f = b1f | dc;
      ev(3, {1'b0, dc});
      if (i < 2) ev(2, 3'h2);
    end
    acc(1'b0, 1'b1, FES_OFF_STATUS, 32'h0, st(2'h0, 2'h0, 3'h5, 3'h2, 3'h0, b1f, b0f));
    acc(1'b0, 1'b1, FES_OFF_STATUS, 32'h0, 32'h0);
    acc(1'b1, 1'b0, FES_OFF_IRQ_STAT, 32'hF, 32'h0);
    for (int i = 0; i < 10; i++) ev(3, 3'h2);
    acc(1'b0, 1'b1, FES_OFF_STATUS, 32'h0, st(2'h0, 2'h0, 3'h7, 3'h0, 3'h0, 2'h2, 2'h0));
    acc(1'b0, 1'b1, FES_OFF_IRQ_STAT, 32'h0, 32'hA);
    acc(1'b1, 1'b0, FES_OFF_IRQ_STAT, 32'hF, 32'h0);
    $display("test tally done");
    for (int i = 0; i < 2; i++) begin
      sg = (i == 0) ? 3'h1 : 3'(1 + {$random(seed)} % 7);
      ev(4, sg);
      acc(1'b0, 1'b1, FES_OFF_STATUS, 32'h0, st(2'h0, 2'h0, 3'h0, 3'h0, sg, 2'h0, 2'h0));
      acc(1'b0, 1'b1, FES_OFF_STATUS, 32'h0, st(2'h0, 2'h0, 3'h0, 3'h0, sg, 2'h0, 2'h0));
    end
    acc(1'b0, 1'b1, FES_OFF_IRQ_STAT, 32'h0, 32'h4);
    $display("test signature done");
    acc(1'b1, 1'b0, FES_OFF_IRQ_STAT, 32'hF, 32'h0);
    ev(0, 3'h2);
    chk_irq(1'b1);
    `CHK("pending reads", 0, expq.size())
    close_out();
  end
endmodule
bind fes_ecc_status fes_ecc_status_sva u_sva (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ibus_ecc_valid(ibus_ecc_valid), .ibus_ecc_code(ibus_ecc_code), .dbus_ecc_valid(dbus_ecc_valid),
  .dbus_ecc_code(dbus_ecc_code), .bank0_ecc_valid(bank0_ecc_valid), .bank1_ecc_valid(bank1_ecc_valid),
  .sig_check_valid(sig_check_valid), .sig_check_code(sig_check_code), .irq(irq));
